// ===== rtl/mpw_defs.svh
`ifndef MPW_DEFS_SVH
`define MPW_DEFS_SVH
// register byte offsets, one aligned 32-bit word each
`define MPW_OFS_CTRL 8'h00
`define MPW_OFS_PERIOD 8'h04
`define MPW_OFS_SEVT 8'h08
`define MPW_OFS_KEY 8'h0C
`define MPW_OFS_STATUS 8'h10
`define MPW_OFS_DUTY0 8'h20
`define MPW_OFS_TRIG0 8'h30
`define MPW_OFS_OVR0 8'h40
`define MPW_OFS_FLT0 8'h50
// unlock keys
`define MPW_KEY_FIRST 16'hABCD
`define MPW_KEY_SECOND 16'h4321
// fault mode field codes
`define MPW_FMODE_LATCH 2'b00
`define MPW_FMODE_CYCLE 2'b01
`define MPW_FMODE_OFF 2'b11
// reset values
`define MPW_RST_PERIOD 16'hFFF8
`define MPW_RST_FLT 5'h0_0
// control register field positions
`define MPW_CTRL_EN 0
`define MPW_CTRL_SYNCEN 1
`define MPW_CTRL_SYNCOEN 2
`define MPW_CTRL_SYNCPOL 3
`define MPW_CTRL_PS_LSB 4
// status register field positions
`define MPW_STAT_LATCH_LSB 0
`define MPW_STAT_LOCK_LSB 4
`define MPW_STAT_BLOCKED 6
`endif

// ===== rtl/mpw_pkg.sv
package mpw_pkg;
   // unlock sequencer states
   typedef enum logic [1:0] {
      LK_IDLE,
      LK_KEY1,
      LK_OPEN
   } mpw_lock_state_type;
   // fault and current-limit control fields, per generator
   typedef struct packed {
      logic safe_low;
      logic safe_high;
      logic cl_en;
      logic [1:0] fault_mode_field;
   } mpw_flt_ctrl_type;
   // output override fields, per generator
   typedef struct packed {
      logic ovr_low_val;
      logic ovr_high_val;
      logic ovr_low_en;
      logic ovr_high_en;
   } mpw_ovr_ctrl_type;
endpackage

// ===== rtl/mpw_top.sv
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`include "mpw_defs.svh"
// Contract
// - three generators, each a high/low pair
// - edges placed at one clock, finer than 8.32ns
// - one master time base aligns all generators
// - enabled faults and limits force safe outputs
// - each generator triggers ADC at programmed count
// - special event trigger from master time base
// - external sync input restarts master time base
// - sync output pin driven from time base
// - class B fault always owned, every reset
// - class B fault latched and active after reset
// - fault mode field writable whatever the pin level
// - override and fault control are write protected
// - protected writes without unlock are blocked
// - config bit one enables protection, zero disables
// - only the very next access is unlocked
// - one unlock admits exactly one protected write
module mpw_top #(
   parameter int NGEN = 3 // generator count
) (
   input wire logic i_sys_clk, // 200 MHz clock
   input wire logic i_rstn, // async reset, active low
   input wire logic [7:0] i_avs_address, // byte address
   input wire logic i_avs_read, // read request
   input wire logic i_avs_write, // write request
   input wire logic [3:0] i_avs_byteenable, // write lanes
   input wire logic [31:0] i_avs_writedata, // write data
   output logic [31:0] o_avs_readdata, // read data
   output logic o_avs_waitrequest, // stall
   input wire logic i_write_protect_cfg_bit, // config option bit
   input wire logic [NGEN-1:0] i_fault_pin, // per-generator fault
   input wire logic [NGEN-1:0] i_climit_pin, // per-generator limit
   input wire logic i_class_b_fault_pin, // class B fault
   input wire logic i_ext_sync_input, // sync in pin
   output logic o_ext_sync_output, // sync out pin
   output logic [NGEN-1:0] o_gen_high_side_out, // high outputs
   output logic [NGEN-1:0] o_gen_low_side_out, // low outputs
   output logic [NGEN-1:0] o_adc_trig, // per-generator trigger
   output logic o_special_evt_trig // master trigger
);
   ////////////////////////////////////////////////////////////////
   // pin synchronisers: two flops, second stage only is read
   logic [NGEN*2+2:0] pin_s1_q, pin_s2_q; // sync stages
   logic sync_prev_q; // sync level, last cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         sync_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= {i_write_protect_cfg_bit, i_class_b_fault_pin,
                      i_ext_sync_input, i_climit_pin, i_fault_pin};
         pin_s2_q <= pin_s1_q;
         sync_prev_q <= pin_s2_q[NGEN*2];
      end
   end
   wire logic [NGEN-1:0] flt_s = pin_s2_q[NGEN-1:0]; // faults
   wire logic [NGEN-1:0] cl_s = pin_s2_q[NGEN*2-1:NGEN]; // limits
   wire logic sync_s = pin_s2_q[NGEN*2]; // sync in level
   wire logic clsb_s = pin_s2_q[NGEN*2+1]; // class B level
   wire logic lock_cfg_s = pin_s2_q[NGEN*2+2]; // protection option

   ////////////////////////////////////////////////////////////////
   // register state and avalon slave
   logic ack_q, ack_d; // answer cycle
   logic [31:0] rdata_q, rdata_d; // read data
   logic [7:0] ctrl_q, ctrl_d; // enable, sync, postscale
   logic [15:0] period_q, period_d; // time base period
   logic [15:0] sevt_q, sevt_d; // special event compare
   logic [15:0] duty_q [NGEN], duty_d [NGEN]; // duty counts
   logic [15:0] trig_q [NGEN], trig_d [NGEN]; // adc trigger counts
   mpw_pkg::mpw_ovr_ctrl_type ovr_q [NGEN], ovr_d [NGEN];
   mpw_pkg::mpw_flt_ctrl_type flt_q [NGEN], flt_d [NGEN];
   logic clsb_latch_q, clsb_latch_d; // class B latched fault
   logic [NGEN-1:0] flt_latch_q, flt_latch_d; // latched faults
   logic blocked_q, blocked_d; // sticky: protected write refused
   mpw_pkg::mpw_lock_state_type lk_q, lk_d; // unlock sequencer
   logic wrap; // time base at period end
   logic [31:0] wmask; // byte enables as a bit mask
   logic take; // access taken this edge
   logic key_wr; // write to key register
   logic prot_ok; // protected write allowed now

   // waitrequest falls one cycle after the request rises
   assign take = (i_avs_read | i_avs_write) & ack_q;
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign o_avs_readdata = rdata_q;
   assign key_wr = take & i_avs_write & (i_avs_address == `MPW_OFS_KEY);
   // option bit 1 enables protection, 0 leaves registers open
   assign prot_ok = ~lock_cfg_s | (lk_q == mpw_pkg::LK_OPEN);

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
      end
   end

   // merge a write into an old value under the byte mask
   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wmask) | (i_avs_writedata & wmask);
   endfunction

   // unlock sequencer: only taken accesses move it; in idle only the first key does
   always_comb begin
      lk_d = lk_q;
      if (take) begin
         case (lk_q)
            mpw_pkg::LK_IDLE: begin
               if (key_wr && i_avs_writedata[15:0] == `MPW_KEY_FIRST) begin
                  lk_d = mpw_pkg::LK_KEY1;
               end
            end
            mpw_pkg::LK_KEY1: begin
               if (key_wr && i_avs_writedata[15:0] == `MPW_KEY_SECOND) begin
                  lk_d = mpw_pkg::LK_OPEN;
               end else begin
                  lk_d = mpw_pkg::LK_IDLE;
               end
            end
            // whatever the next access is, the window closes
            default: lk_d = mpw_pkg::LK_IDLE;
         endcase
      end
   end

   // register writes, reads and hardware-set flags
   always_comb begin
      logic [31:0] m;
      logic [NGEN-1:0] clr;
      logic clr_b;
      m = '0;
      clr = '0;
      clr_b = 1'b0;
      ack_d = (i_avs_read | i_avs_write) & ~ack_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      period_d = period_q;
      sevt_d = sevt_q;
      duty_d = duty_q;
      trig_d = trig_q;
      ovr_d = ovr_q;
      flt_d = flt_q;
      blocked_d = blocked_q;
      if (take && i_avs_write) begin
         if (i_avs_address == `MPW_OFS_CTRL) begin
            m = merge({24'h00_0000, ctrl_q});
            ctrl_d = m[7:0];
         end else if (i_avs_address == `MPW_OFS_PERIOD) begin
            m = merge({16'h0000, period_q});
            period_d = m[15:0];
         end else if (i_avs_address == `MPW_OFS_SEVT) begin
            m = merge({16'h0000, sevt_q});
            sevt_d = m[15:0];
         end else if (i_avs_address == `MPW_OFS_STATUS) begin
            m = i_avs_writedata & wmask; // write one to clear
            clr = m[`MPW_STAT_LATCH_LSB +: NGEN];
            clr_b = m[`MPW_STAT_LATCH_LSB + 3];
            blocked_d = blocked_q & ~m[`MPW_STAT_BLOCKED];
         end else begin
            for (int g = 0; g < NGEN; g++) begin
               if (i_avs_address == `MPW_OFS_DUTY0 + 8'(4 * g)) begin
                  m = merge({16'h0000, duty_q[g]});
                  duty_d[g] = m[15:0];
               end else if (i_avs_address == `MPW_OFS_TRIG0 + 8'(4 * g)) begin
                  m = merge({16'h0000, trig_q[g]});
                  trig_d[g] = m[15:0];
               end else if (i_avs_address == `MPW_OFS_OVR0 + 8'(4 * g)) begin
                  if (prot_ok) begin
                     m = merge({28'h000_0000, ovr_q[g]});
                     ovr_d[g] = m[3:0];
                  end else begin
                     blocked_d = 1'b1;
                  end
               end else if (i_avs_address == `MPW_OFS_FLT0 + 8'(4 * g)) begin
                  // fault mode takes the write whatever the class B pin
                  if (prot_ok) begin
                     m = merge({27'h000_0000, flt_q[g]});
                     flt_d[g] = m[4:0];
                  end else begin
                     blocked_d = 1'b1;
                  end
               end
            end
         end
      end
      // read mux; unmapped and key read as zero
      if (ack_d && i_avs_read) begin
         rdata_d = '0;
         if (i_avs_address == `MPW_OFS_CTRL) begin
            rdata_d[7:0] = ctrl_q;
         end else if (i_avs_address == `MPW_OFS_PERIOD) begin
            rdata_d[15:0] = period_q;
         end else if (i_avs_address == `MPW_OFS_SEVT) begin
            rdata_d[15:0] = sevt_q;
         end else if (i_avs_address == `MPW_OFS_STATUS) begin
            rdata_d[`MPW_STAT_LATCH_LSB +: NGEN] = flt_latch_q;
            rdata_d[`MPW_STAT_LATCH_LSB + 3] = clsb_latch_q;
            rdata_d[`MPW_STAT_LOCK_LSB +: 2] = lk_q;
            rdata_d[`MPW_STAT_BLOCKED] = blocked_q;
         end else begin
            for (int g = 0; g < NGEN; g++) begin
               if (i_avs_address == `MPW_OFS_DUTY0 + 8'(4 * g)) begin
                  rdata_d[15:0] = duty_q[g];
               end else if (i_avs_address == `MPW_OFS_TRIG0 + 8'(4 * g)) begin
                  rdata_d[15:0] = trig_q[g];
               end else if (i_avs_address == `MPW_OFS_OVR0 + 8'(4 * g)) begin
                  rdata_d[3:0] = ovr_q[g];
               end else if (i_avs_address == `MPW_OFS_FLT0 + 8'(4 * g)) begin
                  rdata_d[4:0] = flt_q[g];
               end
            end
         end
      end
      // latched faults: a clear only lands while the pin is low,
      // and a pin still high sets again, so the set wins
      clsb_latch_d = (clsb_latch_q & ~(clr_b & ~clsb_s)) | clsb_s;
      for (int g = 0; g < NGEN; g++) begin
         flt_latch_d[g] = (flt_latch_q[g] & ~(clr[g] & ~flt_s[g]))
            | (flt_s[g] & flt_q[g].fault_mode_field == `MPW_FMODE_LATCH);
      end
   end

   // the class B latch resets set: outputs safe until cleared
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         ctrl_q <= '0;
         period_q <= `MPW_RST_PERIOD;
         sevt_q <= '0;
         for (int g = 0; g < NGEN; g++) begin
            duty_q[g] <= '0;
            trig_q[g] <= '0;
            ovr_q[g] <= '0;
            flt_q[g] <= `MPW_RST_FLT; // latched mode
         end
         clsb_latch_q <= 1'b1;
         flt_latch_q <= '0;
         blocked_q <= 1'b0;
         lk_q <= mpw_pkg::LK_IDLE;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         period_q <= period_d;
         sevt_q <= sevt_d;
         duty_q <= duty_d;
         trig_q <= trig_d;
         ovr_q <= ovr_d;
         flt_q <= flt_d;
         clsb_latch_q <= clsb_latch_d;
         flt_latch_q <= flt_latch_d;
         blocked_q <= blocked_d;
         lk_q <= lk_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // master time base, triggers and outputs
   logic [15:0] tmr_q, tmr_d; // master count, one step per clock
   logic [3:0] ps_q, ps_d; // special event postscale count
   logic cyc_q [NGEN], cyc_d [NGEN]; // cycle-by-cycle hold
   logic [NGEN-1:0] hi_d, lo_d, trg_d; // next outputs
   logic sevt_d_o, synco_d; // next trigger and sync out
   logic sync_edge; // external sync active edge

   // polarity bit makes the sync pins active low
   assign sync_edge = (sync_s ^ ctrl_q[`MPW_CTRL_SYNCPOL])
      & ~(sync_prev_q ^ ctrl_q[`MPW_CTRL_SYNCPOL]);
   assign wrap = (tmr_q >= period_q);

   always_comb begin
      logic safe;
      safe = 1'b0;
      tmr_d = tmr_q;
      ps_d = ps_q;
      sevt_d_o = 1'b0;
      synco_d = ctrl_q[`MPW_CTRL_SYNCPOL];
      hi_d = '0;
      lo_d = '0;
      trg_d = '0;
      cyc_d = cyc_q;
      if (!ctrl_q[`MPW_CTRL_EN]) begin
         tmr_d = '0;
         ps_d = '0;
      end else begin
         // one count per 5 ns clock gives sub-8.32 ns edges
         if (wrap || (ctrl_q[`MPW_CTRL_SYNCEN] && sync_edge)) begin
            tmr_d = '0;
         end else begin
            tmr_d = tmr_q + 16'h0001;
         end
         // sync out pulses at every period wrap, not on a sync restart
         synco_d = ctrl_q[`MPW_CTRL_SYNCPOL] ^
            (ctrl_q[`MPW_CTRL_SYNCOEN] & wrap);
         if (tmr_q == sevt_q) begin
            if (ps_q == ctrl_q[`MPW_CTRL_PS_LSB +: 4]) begin
               ps_d = '0;
               sevt_d_o = 1'b1;
            end else begin
               ps_d = ps_q + 4'h1;
            end
         end
      end
      for (int g = 0; g < NGEN; g++) begin
         // every pair compares against the same master count
         hi_d[g] = ctrl_q[`MPW_CTRL_EN] & (tmr_q < duty_q[g]);
         lo_d[g] = ctrl_q[`MPW_CTRL_EN] & ~hi_d[g];
         trg_d[g] = ctrl_q[`MPW_CTRL_EN] & (tmr_q == trig_q[g]);
         // cycle mode holds safe to the next period boundary
         if (flt_q[g].fault_mode_field == `MPW_FMODE_CYCLE && flt_s[g]) begin
            cyc_d[g] = 1'b1;
         end else if (wrap) begin
            cyc_d[g] = 1'b0;
         end
         if (ovr_q[g].ovr_high_en) begin
            hi_d[g] = ovr_q[g].ovr_high_val;
         end
         if (ovr_q[g].ovr_low_en) begin
            lo_d[g] = ovr_q[g].ovr_low_val;
         end
         // class B ignores mode and override: it always wins
         safe = clsb_latch_q | flt_latch_q[g] | cyc_q[g]
            | (flt_q[g].cl_en & cl_s[g]);
         if (safe) begin
            hi_d[g] = flt_q[g].safe_high;
            lo_d[g] = flt_q[g].safe_low;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tmr_q <= '0;
         ps_q <= '0;
         for (int g = 0; g < NGEN; g++) begin
            cyc_q[g] <= 1'b0;
         end
         o_gen_high_side_out <= '0;
         o_gen_low_side_out <= '0;
         o_adc_trig <= '0;
         o_special_evt_trig <= 1'b0;
         o_ext_sync_output <= 1'b0;
      end else begin
         tmr_q <= tmr_d;
         ps_q <= ps_d;
         cyc_q <= cyc_d;
         o_gen_high_side_out <= hi_d;
         o_gen_low_side_out <= lo_d;
         o_adc_trig <= trg_d;
         o_special_evt_trig <= sevt_d_o;
         o_ext_sync_output <= synco_d;
      end
   end
endmodule // mpw_top

// ===== testbench/mpw_chk_sva.sv
//////////////////////////////////////////////////////////////////////////////
// checker on the top ports; all in the one clock domain
module mpw_chk #(
   parameter int NGEN = 3 // generator count
) (
   input wire logic i_sys_clk, // clock
   input wire logic i_rstn, // reset, active low
   input wire logic i_avs_read, // read request
   input wire logic i_avs_write, // write request
   input wire logic o_avs_waitrequest, // stall
   input wire logic [31:0] o_avs_readdata, // read data
   input wire logic [NGEN-1:0] o_gen_high_side_out, // high outputs
   input wire logic [NGEN-1:0] o_gen_low_side_out, // low outputs
   input wire logic [NGEN-1:0] o_adc_trig, // adc triggers
   input wire logic o_special_evt_trig // master trigger
);
   default clocking cb_main @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   // a fresh request always sees one wait cycle
   a_wait_first: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
      else $error("no wait cycle on new request");
   // and never more than one
   a_wait_once: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest |=>
      !o_avs_waitrequest)
      else $error("request stalled too long");
   a_idle_nowait: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
      else $error("stall without request");
   // outputs come out of reset in the safe state
   a_reset_safe: assert property ($rose(i_rstn) |-> o_gen_high_side_out == '0 &&
      o_gen_low_side_out == '0)
      else $error("outputs not safe after reset");
   // read data only moves on a read answer
   a_read_stable: assert property (!$stable(o_avs_readdata) |->
      $past(i_avs_read && o_avs_waitrequest))
      else $error("read data moved without read");
   // adc triggers 0 and last and the special trigger are single pulses
   a_adc_first: assert property (o_adc_trig[0] |=> !o_adc_trig[0] [*2])
      else $error("adc trigger 0 too long");
   a_adc_last: assert property (o_adc_trig[NGEN-1] |=> !o_adc_trig[NGEN-1])
      else $error("adc trigger last too long");
   a_sevt_pulse: assert property (o_special_evt_trig |=> !o_special_evt_trig)
      else $error("special trigger too long");
endmodule // mpw_chk

// ===== testbench/mpw_stage_model.sv
//////////////////////////////////////////////////////////////////////////////
// power stage and fault sensors on the far side of the outputs
module mpw_stage_model (
   input wire logic i_sys_clk, // clock
   input wire logic i_classb_cmd, // bench asks for a class B trip
   input wire logic [2:0] i_fault_cmd, // bench asks for gate faults
   input wire logic i_sync_cmd, // bench asks for external sync pulses
   output logic o_class_b_fault_pin, // class B line
   output logic [2:0] o_fault_pin, // fault lines
   output logic [2:0] o_climit_pin, // current limit lines
   output logic o_ext_sync_input // sync line toward the block
);
   timeunit 1ns;
   timeprecision 1ps;
   int sync_div = 0; // external master divider, a pulse every 5 clocks
   initial begin
      o_class_b_fault_pin = 1'b0;
      o_fault_pin = 3'h0;
      o_climit_pin = 3'h0;
      o_ext_sync_input = 1'b0;
   end
   // pull-down keeps the class B line low unless a trip is asked
   always @(posedge i_sys_clk) begin
      o_class_b_fault_pin <= i_classb_cmd;
      o_fault_pin <= i_fault_cmd;
      o_climit_pin <= 3'h0; // no overcurrent in this stage
      sync_div <= (sync_div + 1) % 5;
      o_ext_sync_input <= i_sync_cmd && sync_div == 0;
   end
endmodule // mpw_stage_model

// ===== testbench/test_mpw_top.sv
`include "mpw_defs.svh"
module test_mpw_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [7:0] i_avs_address;
   logic [3:0] i_avs_byteenable;
   logic [31:0] i_avs_writedata, o_avs_readdata, q;
   logic i_write_protect_cfg_bit, i_class_b_fault_pin, i_ext_sync_input;
   logic o_ext_sync_output, o_special_evt_trig, classb_cmd, sync_cmd;
   logic [2:0] i_fault_pin, i_climit_pin, o_gen_high_side_out, o_gen_low_side_out, o_adc_trig;
   logic [2:0] fault_cmd;
   logic [31:0] rnd = 32'h262c_0c43;
   logic [31:0] hcnt[3] = '{0, 0, 0}, lcnt[3] = '{0, 0, 0}, acnt[3] = '{0, 0, 0};
   logic [31:0] scnt = '0, ycnt = '0;
   int n_mismatch = 0;
   int num_checks = 0;
   int lock_st, blk, cb, flt[3], ovr[3]; // reference model state
   //////////////////////////////////////////////////////////////////////////////
   mpw_top u_mpw_top (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_write_protect_cfg_bit(i_write_protect_cfg_bit),
      .i_fault_pin(i_fault_pin), .i_climit_pin(i_climit_pin),
      .i_class_b_fault_pin(i_class_b_fault_pin), .i_ext_sync_input(i_ext_sync_input),
      .o_ext_sync_output(o_ext_sync_output), .o_gen_high_side_out(o_gen_high_side_out),
      .o_gen_low_side_out(o_gen_low_side_out), .o_adc_trig(o_adc_trig),
      .o_special_evt_trig(o_special_evt_trig));
   mpw_stage_model u_mpw_stage_model (.i_sys_clk(i_sys_clk), .i_classb_cmd(classb_cmd),
      .i_fault_cmd(fault_cmd), .i_sync_cmd(sync_cmd), .o_class_b_fault_pin(i_class_b_fault_pin),
      .o_fault_pin(i_fault_pin), .o_climit_pin(i_climit_pin), .o_ext_sync_input(i_ext_sync_input));
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [31:0] stat();
      return 32'(blk * 64 + lock_st * 16 + cb * 8);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // reference: unlock sequencer, protected registers, status bits
   task automatic model(input bit wr, input logic [7:0] a, input logic [31:0] d);
      bit prot;
      int g;
      prot = wr && (a[7:4] == 4'h4 || a[7:4] == 4'h5) && a[3:2] < 2'd3;
      g = a[3:2];
      if (wr && a == `MPW_OFS_KEY) begin
         if (lock_st == 0 && d[15:0] == `MPW_KEY_FIRST) lock_st = 1;
         else if (lock_st == 1 && d[15:0] == `MPW_KEY_SECOND) lock_st = 2;
         else lock_st = 0;
      end else begin
         if (prot && (lock_st == 2 || !i_write_protect_cfg_bit)) begin
            if (a[4]) flt[g] = d[4:0];
            else ovr[g] = d[3:0];
         end else if (prot) blk = 1;
         if (wr && a == `MPW_OFS_STATUS) begin
            if (d[6]) blk = 0;
            if (d[3] && !i_class_b_fault_pin) cb = 0;
         end
         lock_st = 0;
      end
   endtask
   // one bus access: hold until waitrequest is seen low, then release
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) n_mismatch++;
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      model(wr, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
   endtask
   task automatic unlock();
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_FIRST});
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_SECOND});
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      {i_rstn, i_avs_read, i_avs_write, classb_cmd, sync_cmd} = 5'h00;
      {i_avs_address, i_avs_writedata, fault_cmd} = '0;
      i_avs_byteenable = 4'hF;
      i_write_protect_cfg_bit = 1'b1;
      {lock_st, blk, cb} = {32'd0, 32'd0, 32'd1};
      flt = '{0, 0, 0};
      ovr = '{0, 0, 0};
      repeat (6) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      chk({26'd0, o_gen_high_side_out, o_gen_low_side_out}, 32'h0000_0000);
      rd(`MPW_OFS_STATUS, 32'h0000_007F, stat());
      rnd = xs(rnd);
      bus(1'b1, `MPW_OFS_FLT0, rnd);
      rd(`MPW_OFS_FLT0, 32'h0000_001F, 32'(flt[0]));
      // one unlock per protected write, all three generators
      for (int g = 0; g < 3; g++) begin
         unlock();
         rnd = xs(rnd);
         bus(1'b1, 8'(`MPW_OFS_FLT0 + 4 * g), rnd);
         rd(8'(`MPW_OFS_FLT0 + 4 * g), 32'h0000_001F, 32'(flt[g]));
      end
      unlock();
      bus(1'b1, `MPW_OFS_OVR0, rnd);
      bus(1'b1, `MPW_OFS_FLT0, ~rnd);
      rd(`MPW_OFS_OVR0, 32'h0000_000F, 32'(ovr[0]));
      rd(`MPW_OFS_FLT0, 32'h0000_001F, 32'(flt[0]));
      // repeated first key, then an access squeezed into the sequence
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_FIRST});
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_FIRST});
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_SECOND});
      bus(1'b1, `MPW_OFS_OVR0 + 8'h04, ~rnd);
      rd(`MPW_OFS_OVR0 + 8'h04, 32'h0000_000F, 32'(ovr[1]));
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_FIRST});
      bus(1'b0, `MPW_OFS_CTRL, 32'h0000_0000);
      bus(1'b1, `MPW_OFS_KEY, {16'h0000, `MPW_KEY_SECOND});
      bus(1'b1, `MPW_OFS_OVR0 + 8'h08, ~rnd);
      rd(`MPW_OFS_OVR0 + 8'h08, 32'h0000_000F, 32'(ovr[2]));
      rd(`MPW_OFS_STATUS, 32'h0000_007F, stat());
      bus(1'b1, `MPW_OFS_STATUS, 32'h0000_0040);
      // class B clear refused while the pin is high, mode still writable
      classb_cmd <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      bus(1'b1, `MPW_OFS_STATUS, 32'h0000_0008);
      rd(`MPW_OFS_STATUS, 32'h0000_007F, stat());
      unlock();
      bus(1'b1, `MPW_OFS_FLT0, 32'h0000_0001);
      rd(`MPW_OFS_FLT0, 32'h0000_001F, 32'(flt[0]));
      classb_cmd <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
      bus(1'b1, `MPW_OFS_STATUS, 32'h0000_0008);
      rd(`MPW_OFS_STATUS, 32'h0000_007F, stat());
      // protection switched off: plain writes land
      i_write_protect_cfg_bit <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      rnd = xs(rnd);
      bus(1'b1, `MPW_OFS_FLT0 + 8'h04, rnd);
      rd(`MPW_OFS_FLT0 + 8'h04, 32'h0000_001F, 32'(flt[1]));
      rd(`MPW_OFS_STATUS, 32'h0000_007F, stat());
      // run the time base: period 10 counts, duty 2/4/6
      bus(1'b1, `MPW_OFS_PERIOD, 32'h0000_0009);
      bus(1'b1, `MPW_OFS_SEVT, 32'h0000_0003);
      for (int g = 0; g < 3; g++) begin
         bus(1'b1, 8'(`MPW_OFS_DUTY0 + 4 * g), 32'(2 * (g + 1)));
         bus(1'b1, 8'(`MPW_OFS_TRIG0 + 4 * g), 32'h0000_0002);
         bus(1'b1, 8'(`MPW_OFS_OVR0 + 4 * g), 32'h0000_0000);
         bus(1'b1, 8'(`MPW_OFS_FLT0 + 4 * g), 32'h0000_000B);
      end
      bus(1'b1, `MPW_OFS_CTRL, 32'h0000_0005);
      repeat (5) @(negedge i_sys_clk);
      // two whole periods give exact counts whatever the phase
      repeat (20) begin
         @(negedge i_sys_clk);
         for (int g = 0; g < 3; g++) begin
            hcnt[g] += 32'(o_gen_high_side_out[g]);
            lcnt[g] += 32'(o_gen_low_side_out[g]);
            acnt[g] += 32'(o_adc_trig[g]);
         end
         scnt += 32'(o_special_evt_trig);
         ycnt += 32'(o_ext_sync_output);
      end
      for (int g = 0; g < 3; g++) begin
         chk(hcnt[g], 32'(4 * (g + 1)));
         chk(lcnt[g], 32'(20 - 4 * (g + 1)));
         chk(acnt[g], 32'h0000_0002);
      end
      chk(scnt, 32'h0000_0002);
      chk(ycnt, 32'h0000_0002);
      // sync in every 5 counts restarts the base before it can wrap
      sync_cmd <= 1'b1;
      bus(1'b1, `MPW_OFS_CTRL, 32'h0000_0007);
      repeat (10) @(negedge i_sys_clk);
      ycnt = '0;
      repeat (20) @(negedge i_sys_clk) ycnt += 32'(o_ext_sync_output);
      chk(ycnt, 32'h0000_0000);
      // class B trip mid-run forces the safe levels
      classb_cmd <= 1'b1;
      repeat (8) @(negedge i_sys_clk);
      chk({26'd0, o_gen_high_side_out, o_gen_low_side_out}, 32'h0000_0038);
      test_done();
   end
endmodule // test_mpw_top
bind mpw_top mpw_chk #(.NGEN(NGEN)) u_mpw_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
   .o_avs_readdata(o_avs_readdata), .o_gen_high_side_out(o_gen_high_side_out),
   .o_gen_low_side_out(o_gen_low_side_out), .o_adc_trig(o_adc_trig),
   .o_special_evt_trig(o_special_evt_trig));
